// ### rtl/dtm_pkg.sv
/*
  Constants, types and helpers of the debug trace and monitor port.
  Assumes a 10 MHz core clock and a 32-bit internal bus with byte addresses.
*/
package dtm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TRACE_DLY_NS = 300;
  localparam int TRACE_DLY_CYC = (TRACE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TRACE_DLY_LOAD = 3'(TRACE_DLY_CYC - 1);

  // ---------------------------------------------------------------
  // Nibble codes
  // ---------------------------------------------------------------
  localparam logic [3:0] NIB_IDLE = 4'h3;
  localparam logic [1:0] NIB_HDR_TAG = 2'h2;
  localparam logic [3:0] NIB_NOTRDY = 4'h0;
  localparam logic [3:0] NIB_RDY = 4'h1;
  localparam int FLAG_CMDERR_BIT = 1;
  localparam int FLAG_BUSERR_BIT = 2;
  localparam logic [31:0] REF_RESET = 32'h0000_0000;

  // Command nibble: [3:2] direction, [1:0] access size
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [3:0] ADDR_NIBS = 4'h8;

  // Address spaces used by the bus error check
  localparam logic [31:0] IO8_LO = 32'hffff_e000;
  localparam logic [31:0] IO8_HI = 32'hffff_efff;
  localparam logic [31:0] EXT_LO = 32'h0040_0000;
  localparam logic [31:0] EXT_HI = 32'hfff7_ffff;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_REF = 8'h08;
  localparam int CTRL_SRST_BIT = 0;
  localparam int CTRL_MSTOP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dtm_bus_req_s;

  typedef enum logic [3:0] {
    TRC_IDLE = 4'h1,
    TRC_WAIT = 4'h2,
    TRC_HDR = 4'h4,
    TRC_ADDR = 4'h8
  } dtm_trc_e;

  typedef enum logic [5:0] {
    MON_CMD = 6'h01,
    MON_ADDR = 6'h02,
    MON_WDATA = 6'h04,
    MON_ACC = 6'h08,
    MON_FLAG = 6'h10,
    MON_RDATA = 6'h20
  } dtm_mon_e;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] dtm_size_code(input logic [31:0] a, input logic [31:0] r);
    if (a[31:4] == r[31:4])
      return 2'h0;
    else if (a[31:8] == r[31:8])
      return 2'h1;
    else if (a[31:16] == r[31:16])
      return 2'h2;
    else
      return 2'h3;
  endfunction : dtm_size_code

  // Nibbles carried for a 2-bit size code: 1, 2, 4 or 8
  function automatic logic [3:0] dtm_nibs(input logic [1:0] code);
    return 4'(4'h1 << code);
  endfunction : dtm_nibs

endpackage : dtm_pkg

// ### rtl/dtm_port.sv
/*
  Debug trace and monitor port: branch trace output and memory monitor
  access over a 4-bit nibble bus, plus an APB register slave.
  Assumes pins are asynchronous to clk_i, an internal bus that answers
  with done or error, and standby levels from the system controller.
*/
// Our own choices: the address map and the APB register port.
//
// Behaviour
// - Trace idle drives 0011 on every debug clock cycle.
// - Branch sends one 10xx header nibble, then sync low with address nibbles.
// - Size picked against last fully sent address; reference resets to zero.
// - After last address nibble, sync negated and bus returns to 0011.
// - New branch aborts output, negates sync, resends header and new address.
// - Only a completely sent address becomes the new reference.
// - Header starts 1.5 or 2 debug clocks after the branch.
// - Host asserts sync with input nibbles; device latches only while asserted.
// - After full command, start bus access and return 0000 meanwhile.
// - Successful access returns ready nibble 0001.
// - Read data of the commanded size follows once host negates sync.
// - Undefined command abandons the operation and sets flag bit 1.
// - Bus error abandons the operation and sets flag bit 2.
// - Flag bit 3 is zero, bits 2..1 zero normally, bit 0 ready.
// - Word access at odd address and unaligned longword give bus error.
// - Longword to 8-bit I/O space, external space in single-chip: bus error.
// - Clear state on reset, hardware standby, debug reset, soft reset, module stop.
// - Software standby: monitor stays not ready; trace halts then resumes.
// - Trace mode drives debug clock at half rate, data synchronous to it.
// - Address nibbles go least significant first, count set by header.
// - Size code 00/01/10 when bits 31..4/31..8/31..16 match, else 11.
`timescale 1ns/1ps

module dtm_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic debug_reset_n_i,
  input wire logic debug_mode_select_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic single_chip_i,
  input wire logic branch_valid_i,
  input wire logic [31:0] branch_addr_i,
  input wire logic debug_clock_i,
  output logic debug_clock_o,
  output logic debug_clock_oe_o,
  input wire logic frame_sync_n_i,
  output logic frame_sync_n_o,
  output logic frame_sync_n_oe_o,
  input wire logic [3:0] nibble_bus_i,
  output logic [3:0] nibble_bus_o,
  output logic nibble_bus_oe_o,
  output dtm_pkg::dtm_bus_req_s ibus_o,
  input wire logic ibus_done_i,
  input wire logic ibus_err_i,
  input wire logic [31:0] ibus_rdata_i
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_s, md_s, hws_s, dck_s, fs_s;
  logic [3:0] nib_s1, nib_s2;
  logic dck_d;
  always_ff @(posedge clk_i)
  begin
    rst_s <= {rst_s[0], debug_reset_n_i};
    md_s <= {md_s[0], debug_mode_select_i};
    hws_s <= {hws_s[0], hw_standby_i};
    dck_s <= {dck_s[0], debug_clock_i};
    fs_s <= {fs_s[0], frame_sync_n_i};
    nib_s1 <= nibble_bus_i;
    nib_s2 <= nib_s1;
    dck_d <= dck_s[1];
  end

  // ---------------------------------------------------------------
  // Control register and unit clear
  // ---------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic dbg_clr, mode_r;
  assign dbg_clr = !resetn_i || !rst_s[1] || hws_s[1] || ctrl_r[dtm_pkg::CTRL_SRST_BIT]
                   || ctrl_r[dtm_pkg::CTRL_MSTOP_BIT];

  // Mode is taken while the unit is held clear and frozen at release
  always_ff @(posedge clk_i)
  begin
    if (dbg_clr)
      mode_r <= md_s[1];
  end

  logic mon_run, trc_run;
  assign mon_run = !dbg_clr && mode_r;
  assign trc_run = !dbg_clr && !mode_r && !sw_standby_i;

  // ---------------------------------------------------------------
  // Branch trace
  // ---------------------------------------------------------------
  dtm_pkg::dtm_trc_e trc_state;
  logic dck_r, pend_r, trc_sync_r, slot;
  logic [2:0] dly_r;
  logic [31:0] pend_addr_r, ref_r, sh_r, cur_addr_r;
  logic [3:0] trc_nib_r, trc_cnt_r, trc_len_r;
  logic [1:0] code;
  assign slot = trc_run && dck_r;
  assign code = dtm_pkg::dtm_size_code(pend_addr_r, ref_r);

  always_ff @(posedge clk_i)
  begin
    if (dbg_clr || mode_r)
      dck_r <= 1'b0;
    else if (trc_run)
      dck_r <= !dck_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (dbg_clr || mode_r)
    begin
      trc_state <= dtm_pkg::TRC_IDLE;
      pend_r <= 1'b0;
      dly_r <= '0;
      pend_addr_r <= '0;
      ref_r <= dtm_pkg::REF_RESET;
      sh_r <= '0;
      cur_addr_r <= '0;
      trc_cnt_r <= '0;
      trc_len_r <= '0;
      trc_nib_r <= dtm_pkg::NIB_IDLE;
      trc_sync_r <= 1'b1;
    end
    else if (trc_run && branch_valid_i)
    begin
      // A new branch drops any output in flight without touching the reference
      pend_addr_r <= branch_addr_i;
      dly_r <= dtm_pkg::TRACE_DLY_LOAD;
      pend_r <= 1'b1;
      trc_state <= dtm_pkg::TRC_WAIT;
      if (slot)
      begin
        trc_nib_r <= dtm_pkg::NIB_IDLE;
        trc_sync_r <= 1'b1;
      end
    end
    else if (trc_run)
    begin
      if (dly_r != 3'h0)
        dly_r <= dly_r - 3'h1;
      if (slot)
      begin
        if (pend_r && dly_r == 3'h0)
        begin
          trc_nib_r <= {dtm_pkg::NIB_HDR_TAG, code};
          trc_sync_r <= 1'b1;
          trc_len_r <= dtm_pkg::dtm_nibs(code);
          trc_cnt_r <= '0;
          sh_r <= pend_addr_r;
          cur_addr_r <= pend_addr_r;
          pend_r <= 1'b0;
          trc_state <= dtm_pkg::TRC_HDR;
        end
        else if (trc_state == dtm_pkg::TRC_HDR || (trc_state == dtm_pkg::TRC_ADDR
                 && trc_cnt_r != trc_len_r))
        begin
          trc_nib_r <= sh_r[3:0];
          sh_r <= {4'h0, sh_r[31:4]};
          trc_sync_r <= 1'b0;
          trc_cnt_r <= trc_cnt_r + 4'h1;
          trc_state <= dtm_pkg::TRC_ADDR;
        end
        else
        begin
          if (trc_state == dtm_pkg::TRC_ADDR)
            ref_r <= cur_addr_r;
          trc_nib_r <= dtm_pkg::NIB_IDLE;
          trc_sync_r <= 1'b1;
          if (trc_state != dtm_pkg::TRC_WAIT)
            trc_state <= dtm_pkg::TRC_IDLE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory monitor
  // ---------------------------------------------------------------
  dtm_pkg::dtm_mon_e mon_state;
  logic dck_rise, dck_fall, fs_on, mon_oe_r, cmd_bad;
  logic [1:0] dir_r, size_r;
  logic [31:0] addr_r, wdata_r, rdata_r;
  logic [3:0] mon_cnt_r, mon_nib_r, data_nibs;
  assign dck_rise = dck_s[1] && !dck_d;
  assign dck_fall = !dck_s[1] && dck_d;
  assign fs_on = !fs_s[1];
  // Data nibbles: 2, 4 or 8 for byte, word, longword
  assign data_nibs = dtm_pkg::dtm_nibs(2'(size_r + 2'h1));
  assign cmd_bad = !(nib_s2[3:2] == dtm_pkg::CMD_READ || nib_s2[3:2] == dtm_pkg::CMD_WRITE)
                   || nib_s2[1:0] == 2'h3;

  function automatic logic bus_fault(input logic [1:0] sz, input logic [31:0] a,
                                     input logic single);
    logic f;
    f = (sz == dtm_pkg::SZ_WORD && a[0]);
    f = f || (sz == dtm_pkg::SZ_LONG && a[1:0] != 2'h0);
    f = f || (sz == dtm_pkg::SZ_LONG && a >= dtm_pkg::IO8_LO && a <= dtm_pkg::IO8_HI);
    f = f || (single && a >= dtm_pkg::EXT_LO && a <= dtm_pkg::EXT_HI);
    return f;
  endfunction : bus_fault

  always_ff @(posedge clk_i)
  begin
    if (!mon_run)
    begin
      mon_state <= dtm_pkg::MON_CMD;
      mon_cnt_r <= '0;
      dir_r <= '0;
      size_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      mon_nib_r <= dtm_pkg::NIB_NOTRDY;
      mon_oe_r <= 1'b0;
      ibus_o <= '0;
    end
    else
    begin
      case (mon_state)
        dtm_pkg::MON_CMD:
          if (dck_rise && fs_on)
          begin
            dir_r <= nib_s2[3:2];
            size_r <= nib_s2[1:0];
            mon_cnt_r <= '0;
            if (cmd_bad)
            begin
              mon_nib_r <= 4'(1 << dtm_pkg::FLAG_CMDERR_BIT) | dtm_pkg::NIB_RDY;
              mon_oe_r <= 1'b1;
              mon_state <= dtm_pkg::MON_FLAG;
            end
            else
              mon_state <= dtm_pkg::MON_ADDR;
          end
        dtm_pkg::MON_ADDR:
          if (dck_rise && fs_on)
          begin
            addr_r <= {nib_s2, addr_r[31:4]};
            mon_cnt_r <= mon_cnt_r + 4'h1;
            if (mon_cnt_r == dtm_pkg::ADDR_NIBS - 4'h1)
            begin
              mon_cnt_r <= '0;
              if (dir_r == dtm_pkg::CMD_WRITE)
                mon_state <= dtm_pkg::MON_WDATA;
              else
              begin
                mon_nib_r <= dtm_pkg::NIB_NOTRDY;
                mon_oe_r <= 1'b1;
                mon_state <= dtm_pkg::MON_ACC;
              end
            end
          end
        dtm_pkg::MON_WDATA:
          if (dck_rise && fs_on)
          begin
            wdata_r <= wdata_r | ({28'h0, nib_s2} << {mon_cnt_r[2:0], 2'h0});
            mon_cnt_r <= mon_cnt_r + 4'h1;
            if (mon_cnt_r == data_nibs - 4'h1)
            begin
              mon_nib_r <= dtm_pkg::NIB_NOTRDY;
              mon_oe_r <= 1'b1;
              mon_state <= dtm_pkg::MON_ACC;
            end
          end
        dtm_pkg::MON_ACC:
          if (bus_fault(size_r, addr_r, single_chip_i))
          begin
            mon_nib_r <= 4'(1 << dtm_pkg::FLAG_BUSERR_BIT) | dtm_pkg::NIB_RDY;
            mon_state <= dtm_pkg::MON_FLAG;
          end
          else if (ibus_o.req && (ibus_done_i || ibus_err_i))
          begin
            ibus_o.req <= 1'b0;
            rdata_r <= ibus_rdata_i;
            mon_nib_r <= ibus_err_i ? (4'(1 << dtm_pkg::FLAG_BUSERR_BIT) | dtm_pkg::NIB_RDY)
                                    : dtm_pkg::NIB_RDY;
            mon_state <= dtm_pkg::MON_FLAG;
          end
          else if (!sw_standby_i)
          begin
            ibus_o <= '{req: 1'b1, we: (dir_r == dtm_pkg::CMD_WRITE), size: size_r,
                        addr: addr_r, wdata: wdata_r};
          end
        dtm_pkg::MON_FLAG:
          if (!fs_on)
          begin
            mon_cnt_r <= '0;
            if (mon_nib_r == dtm_pkg::NIB_RDY && dir_r == dtm_pkg::CMD_READ)
              mon_state <= dtm_pkg::MON_RDATA;
            else
            begin
              mon_oe_r <= 1'b0;
              wdata_r <= '0;
              mon_state <= dtm_pkg::MON_CMD;
            end
          end
        dtm_pkg::MON_RDATA:
          if (dck_fall)
          begin
            if (mon_cnt_r == data_nibs)
            begin
              mon_oe_r <= 1'b0;
              mon_state <= dtm_pkg::MON_CMD;
            end
            else
            begin
              mon_nib_r <= rdata_r[3:0];
              rdata_r <= {4'h0, rdata_r[31:4]};
              mon_cnt_r <= mon_cnt_r + 4'h1;
            end
          end
        default:
          mon_state <= dtm_pkg::MON_CMD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin output stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (dbg_clr)
    begin
      debug_clock_o <= 1'b0;
      debug_clock_oe_o <= 1'b0;
      frame_sync_n_o <= 1'b1;
      frame_sync_n_oe_o <= 1'b0;
      nibble_bus_o <= dtm_pkg::NIB_IDLE;
      nibble_bus_oe_o <= 1'b0;
    end
    else
    begin
      debug_clock_o <= dck_r;
      debug_clock_oe_o <= !mode_r;
      frame_sync_n_o <= mode_r ? 1'b1 : trc_sync_r;
      frame_sync_n_oe_o <= !mode_r;
      nibble_bus_o <= mode_r ? mon_nib_r : trc_nib_r;
      nibble_bus_oe_o <= !mode_r || mon_oe_r;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic hit;
  assign hit = paddr_i == dtm_pkg::REG_CTRL || paddr_i == dtm_pkg::REG_STAT
               || paddr_i == dtm_pkg::REG_REF;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r <= dtm_pkg::CTRL_RESET;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else if (psel_i && !penable_i)
    begin
      pready_o <= 1'b1;
      pslverr_o <= !hit;
      case (paddr_i)
        dtm_pkg::REG_CTRL: prdata_o <= {30'h0, ctrl_r};
        dtm_pkg::REG_STAT: prdata_o <= {24'h0, mon_nib_r, !mon_state[0],
                                        trc_state != dtm_pkg::TRC_IDLE, mon_run, mode_r};
        dtm_pkg::REG_REF: prdata_o <= ref_r;
        default: prdata_o <= '0;
      endcase
    end
    else
    begin
      // A write lands only at the edge that completes the access phase
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == dtm_pkg::REG_CTRL)
        ctrl_r <= pwdata_i[1:0];
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [3:0] br_age;
  always_ff @(posedge clk_i)
  begin
    if (dbg_clr || branch_valid_i)
      br_age <= '0;
    else if (br_age != 4'hf)
      br_age <= br_age + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_IDLE_NIB: assert property (trc_run && trc_state == dtm_pkg::TRC_IDLE && !pend_r
    |-> trc_nib_r == dtm_pkg::NIB_IDLE && trc_sync_r) else $error("trace idle not 0011");
  AST_HDR: assert property (trc_run && $changed(trc_state) && trc_state == dtm_pkg::TRC_HDR
    |-> trc_nib_r[3:2] == 2'h2 && trc_sync_r ##2 !trc_sync_r) else $error("bad header");
  AST_REF_RST: assert property (dbg_clr |=> ref_r == 32'h0) else $error("reference not cleared");
  AST_END: assert property (slot && !branch_valid_i && !pend_r && trc_state == dtm_pkg::TRC_ADDR
    && trc_cnt_r == trc_len_r |=> trc_sync_r && trc_nib_r == 4'h3) else $error("no frame end");
  AST_ABORT_REF: assert property (trc_run && branch_valid_i |=> $stable(ref_r))
    else $error("aborted output moved reference");
  AST_DLY: assert property (trc_run && $changed(trc_state) && trc_state == dtm_pkg::TRC_HDR
    |-> br_age inside {[3:4]}) else $error("header delay off");
  AST_HALF: assert property (trc_run ##1 trc_run |-> dck_r != $past(dck_r))
    else $error("debug clock not half rate");
  AST_NOTRDY: assert property (mon_run && mon_state == dtm_pkg::MON_ACC
    |-> mon_nib_r == 4'h0 && mon_oe_r) else $error("not ready missing");
  AST_CMDERR: assert property (mon_run && mon_state == dtm_pkg::MON_CMD && dck_rise && fs_on && cmd_bad
    |=> mon_state == dtm_pkg::MON_FLAG && mon_nib_r == 4'h3 && !ibus_o.req)
    else $error("command error not flagged");
  AST_FLAG: assert property (mon_run && mon_state == dtm_pkg::MON_FLAG
    |-> !mon_nib_r[3] && mon_nib_r[0]) else $error("flag format");
  AST_ALIGN: assert property (mon_run && mon_state == dtm_pkg::MON_ACC && size_r == 2'h2
    && addr_r[1:0] != 2'h0 |=> !ibus_o.req && mon_nib_r[2]) else $error("unaligned accepted");
  AST_LATCH: assert property (mon_run && !fs_on && mon_state == dtm_pkg::MON_ADDR
    |=> $stable(addr_r)) else $error("latched without sync");

  COV_BRANCH: cover property (trc_state == dtm_pkg::TRC_ADDR ##[1:40] trc_state == dtm_pkg::TRC_IDLE);
  COV_ABORT: cover property (trc_state == dtm_pkg::TRC_ADDR && branch_valid_i);
  COV_READ: cover property (mon_state == dtm_pkg::MON_RDATA);
  COV_BUSERR: cover property (mon_state == dtm_pkg::MON_FLAG && mon_nib_r[2]);

endmodule : dtm_port

// ### testbench/dtm_host_model.sv
/*
  Debugger model for monitor mode: frames commands on the nibble bus.
  Assumes the bench resolves the shared pins and a 10 MHz clk_i.
*/
`timescale 1ns/1ps

module dtm_host_model (
  input wire logic clk_i,
  input wire logic [3:0] wire_i,
  output logic dck_o,
  output logic sync_n_o,
  output logic [3:0] nib_o,
  output logic nib_en_o
);
  initial
  begin
    dck_o = 1'b1;
    sync_n_o = 1'b1;
    nib_o = 4'h0;
    nib_en_o = 1'b0;
  end

  // One debug clock of eight core cycles; clock stands high between frames
  task automatic tick(input logic [3:0] n, input logic en, output logic [3:0] s);
    dck_o <= 1'b0;
    nib_o <= n;
    nib_en_o <= en;
    repeat (4) @(posedge clk_i);
    dck_o <= 1'b1;
    repeat (4) @(negedge clk_i);
    s = wire_i;
    @(posedge clk_i);
  endtask : tick

  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] wd,
      input int nw, input int nr, output logic [3:0] flag, output logic [31:0] rd);
    logic [3:0] s;
    logic [67:0] fr;
    fr = {wd, a, cmd};
    rd = 32'h0;
    flag = 4'h0;
    sync_n_o <= 1'b0;
    for (int i = 0; i < 9 + nw; i++)
      tick(fr[4*i+:4], 1'b1, s);
    for (int i = 0; i < 40 && flag[0] !== 1'b1; i++)
      tick(nib_o, 1'b0, flag);
    sync_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < nr; i++)
    begin
      tick(4'h0, 1'b0, s);
      rd[4*i+:4] = s;
    end
    // Closing falling edge lets the device release the bus
    if (nr > 0)
      tick(4'h0, 1'b0, s);
  endtask : xfer
endmodule : dtm_host_model

// ### testbench/dtm_port_bench.sv
/*
  Self-checking bench of the debug port: APB, branch trace, monitor.
  Assumes dtm_host_model as debugger and a pulled-up nibble bus.
*/
`timescale 1ns/1ps

module dtm_port_bench;
  localparam logic [31:0] RDATA = 32'h5a3c_96e1;
  localparam logic [3:0] RL = {dtm_pkg::CMD_READ, dtm_pkg::SZ_LONG};
  logic clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, acc = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, ba = 32'h0;
  logic pready, pslverr, drn = 1'b0, mode = 1'b0, single = 1'b0, bv = 1'b0;
  logic dck_o, dck_oe, sync_o, sync_oe, nib_oe, h_dck, h_sync, h_en;
  logic done = 1'b0, err = 1'b0, berr = 1'b0, hws = 1'b0, sws = 1'b0;
  logic [3:0] nib_o, h_nib, nwire;
  dtm_pkg::dtm_bus_req_s ibus, last;
  int mismatches = 0, comparisons = 0, cyc = 0;

  always #50 clk_i = ~clk_i;
  assign nwire = nib_oe ? nib_o : (h_en ? h_nib : 4'hf);

  dtm_port dtm_port_inst (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .debug_reset_n_i(drn),
    .debug_mode_select_i(mode), .hw_standby_i(hws), .sw_standby_i(sws),
    .single_chip_i(single), .branch_valid_i(bv), .branch_addr_i(ba),
    .debug_clock_i(dck_oe ? dck_o : h_dck), .debug_clock_o(dck_o), .debug_clock_oe_o(dck_oe),
    .frame_sync_n_i(sync_oe ? sync_o : h_sync), .frame_sync_n_o(sync_o),
    .frame_sync_n_oe_o(sync_oe), .nibble_bus_i(nwire), .nibble_bus_o(nib_o),
    .nibble_bus_oe_o(nib_oe), .ibus_o(ibus), .ibus_done_i(done), .ibus_err_i(err),
    .ibus_rdata_i(RDATA));

  dtm_host_model host_inst (.clk_i(clk_i), .wire_i(nwire), .dck_o(h_dck),
    .sync_n_o(h_sync), .nib_o(h_nib), .nib_en_o(h_en));

  // ---------------------------------------------------------------
  // Internal bus slave and watchdog
  // ---------------------------------------------------------------
  always @(posedge clk_i)
  begin
    acc <= ibus.req ? acc + 8'h1 : 8'h0;
    done <= ibus.req && acc == 8'h14 && !berr;
    err <= ibus.req && acc == 8'h14 && berr;
    if (ibus.req)
      last <= ibus;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic enter(input logic m);
    drn <= 1'b0;
    repeat (4) @(posedge clk_i);
    mode <= m;
    repeat (4) @(posedge clk_i);
    drn <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : enter

  task automatic trace(input logic [31:0] a, input logic [1:0] c, input int k);
    int n;
    time t;
    bv <= 1'b1;
    ba <= a;
    @(posedge clk_i);
    bv <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (n < 9 && !(sync_o === 1'b1 && nib_o[3:2] === 2'b10));
    check(32'(n == 4 || n == 5), 32'h1);
    @(posedge dck_o);
    #1;
    t = $time;
    check(32'({sync_o, nib_o}), 32'({3'b110, c}));
    for (int i = 0; i < k; i++)
    begin
      @(posedge dck_o);
      #1;
      if (i == 0)
        check(32'($time - t), 32'd200);
      check(32'({sync_o, nib_o}), 32'(a[4*i+:4]));
    end
    if (k == 1 << c)
    begin
      @(posedge dck_o);
      #1;
      check(32'({sync_o, nib_o}), 32'h13);
    end
    @(posedge clk_i);
  endtask : trace

  task automatic mon(input logic [3:0] cmd, input logic [31:0] a, input int nw,
      input int nr, input logic [3:0] ef);
    logic [3:0] f;
    logic [31:0] rd;
    host_inst.xfer(cmd, a, 32'h0000_beef, nw, nr, f, rd);
    check(32'(f), 32'(ef));
    if (nr > 0)
      check(rd, RDATA);
    repeat (16) @(posedge clk_i);
  endtask : mon

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic e;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, dtm_pkg::REG_CTRL, 32'h0, rd, e);
    check(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, rd, e);
    check(32'(e), 32'h1);
    enter(1'b0);
    trace(32'h0000_0005, 2'h0, 1);
    trace(32'h0000_0035, 2'h1, 2);
    trace(32'h0000_1235, 2'h2, 4);
    trace(32'h8000_1235, 2'h3, 8);
    trace(32'h0012_3456, 2'h3, 2);
    trace(32'h8000_1237, 2'h0, 1);
    apb(1'b0, dtm_pkg::REG_REF, 32'h0, rd, e);
    check(rd, 32'h8000_1237);
    apb(1'b1, dtm_pkg::REG_CTRL, 32'h1, rd, e);
    apb(1'b1, dtm_pkg::REG_CTRL, 32'h0, rd, e);
    apb(1'b0, dtm_pkg::REG_REF, 32'h0, rd, e);
    check(rd, dtm_pkg::REF_RESET);
    trace(32'h0000_0005, 2'h0, 1);
    sws <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    e = dck_o;
    @(negedge clk_i);
    check(32'(dck_o), 32'(e));
    @(posedge clk_i);
    sws <= 1'b0;
    hws <= 1'b1;
    repeat (4) @(posedge clk_i);
    hws <= 1'b0;
    repeat (4) @(posedge clk_i);
    apb(1'b0, dtm_pkg::REG_REF, 32'h0, rd, e);
    check(rd, dtm_pkg::REF_RESET);
    enter(1'b1);
    apb(1'b0, dtm_pkg::REG_STAT, 32'h0, rd, e);
    check(rd, 32'h3);
    mon(RL, 32'h0000_1000, 0, 8, 4'h1);
    check(32'({last.we, last.size, last.addr[28:0]}), 32'h4000_1000);
    mon({dtm_pkg::CMD_WRITE, dtm_pkg::SZ_WORD}, 32'h0000_2002, 4, 0, 4'h1);
    check(32'({last.we, last.addr[7:0]}), 32'h102);
    check(last.wdata, 32'h0000_beef);
    mon(4'h4, 32'h0000_1000, 0, 0, 4'h3);
    mon({dtm_pkg::CMD_READ, dtm_pkg::SZ_WORD}, 32'h0000_1001, 0, 0, 4'h5);
    mon(RL, 32'h0000_1002, 0, 0, 4'h5);
    mon(RL, dtm_pkg::IO8_LO, 0, 0, 4'h5);
    single <= 1'b1;
    mon({dtm_pkg::CMD_READ, dtm_pkg::SZ_BYTE}, dtm_pkg::EXT_LO, 0, 0, 4'h5);
    single <= 1'b0;
    berr <= 1'b1;
    mon({dtm_pkg::CMD_READ, dtm_pkg::SZ_BYTE}, 32'h0000_2000, 0, 0, 4'h5);
    end_sim();
  end
endmodule : dtm_port_bench
